// file: core_performance_event_counters.sv
// Notes on behaviour
// - Four independent software-visible counters, indices zero to three.
// - Counters are 32 bits and emit an overflow event when enabled.
// - Each counter selects its source from up to 128 event codes.
// - Monitor interrupt raised on any enabled overflow condition.
// - Cycle event counts cycles not waiting, halted, stopped or debugging.
// - Completed-instruction event adds zero to three per cycle.
// - Fetched-word event adds zero to four per cycle.
// - Branches, branch-and-link and conditional branches counted separately.
// - Taken branches and taken conditional branches counted separately.
// - Loads and stores counted, including multiple forms.
// - Simple integer, multiply and divide completions counted separately.
// - All return-from-interrupt variants counted.
// - Decode stall counts cycles with no instruction to decode.
// - Issue stall counts cycles with buffer full but nothing issued.
// - Branch issue stall counts cycles branch waits for resolution.
// - Load stall counts cycles execution waits on load data.
// - All, external and watchdog interrupts taken counted separately.
// - Watchpoint event counts each rising edge of watchpoint indication.
// - Latency event counts request-to-vector waits above threshold.
`timescale 1ns/1ps
module core_performance_event_counters (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire perf_counter_pkg::reg_req_t req,
  output logic [31:0] rdata,
  // Core pipeline indications
  input wire perf_counter_pkg::core_events_t ev,
  // Overflow and interrupt
  output logic [3:0] overflow_event,
  output logic perf_irq
);
  import perf_counter_pkg::*;

  logic [COUNT_W-1:0] count_reg [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] enable_reg;
  logic [NUM_COUNTERS-1:0] ovf_ie_reg;
  logic [EVENT_SEL_W-1:0] sel_reg [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] ovf_status_reg;
  logic freeze_reg;
  logic [15:0] lat_thresh_reg;
  logic wp_prev_reg;
  logic lat_active_reg;
  logic lat_flag_reg;
  logic [15:0] lat_count_reg;
  logic lat_event;
  logic [2:0] inc [NUM_COUNTERS];
  logic [COUNT_W:0] sum [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] wr_count;
  logic [NUM_COUNTERS-1:0] wr_ctrl;

  // Map an event code to its per-cycle increment
  function automatic logic [2:0] event_inc(input logic [6:0] sel,
                                           input core_events_t e,
                                           input logic wp_rise,
                                           input logic lat_hit);
    logic [2:0] v;
    v = 3'h0;
    unique case (sel)
      EV_CYCLES: v = {2'h0, !(e.waiting || e.halted || e.stopped ||
                              e.debug_active)};
      EV_INSTR_DONE: v = {1'b0, e.instr_done};
      EV_WORDS_FETCHED: v = (e.words_fetched > 3'h4) ? 3'h4 :
                            e.words_fetched;
      EV_BRANCH: v = {2'h0, e.branch};
      EV_BRANCH_LINK: v = {2'h0, e.branch_link};
      EV_COND_BRANCH: v = {2'h0, e.cond_branch};
      EV_TAKEN_BRANCH: v = {2'h0, e.taken_branch};
      EV_TAKEN_COND: v = {2'h0, e.taken_cond};
      EV_LOAD: v = {2'h0, e.load};
      EV_STORE: v = {2'h0, e.store};
      EV_INTEGER: v = {2'h0, e.integer_op};
      EV_MULTIPLY: v = {2'h0, e.multiply};
      EV_DIVIDE: v = {2'h0, e.divide};
      EV_RFI: v = {2'h0, e.rfi};
      EV_DECODE_STALL: v = {2'h0, e.decode_empty};
      EV_ISSUE_STALL: v = {2'h0, e.issue_stall};
      EV_BRANCH_STALL: v = {2'h0, e.branch_stall};
      EV_LOAD_STALL: v = {2'h0, e.load_stall};
      EV_INT_TAKEN: v = {2'h0, e.int_taken};
      EV_EXT_INT_TAKEN: v = {2'h0, e.ext_int_taken};
      EV_WDOG_INT_TAKEN: v = {2'h0, e.wdog_int_taken};
      EV_WATCHPOINT: v = {2'h0, wp_rise};
      EV_INT_LATENCY: v = {2'h0, lat_hit};
      default: v = 3'h0;
    endcase
    return v;
  endfunction

  // Match one word slot of a register bank
  function automatic logic slot_hit(input logic [7:0] addr,
                                    input logic [7:0] base,
                                    input int idx);
    return addr == base + 8'(4 * idx);
  endfunction

  // Watchpoint edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_prev_reg <= 1'b0;
    end else begin
      wp_prev_reg <= ev.watchpoint_indication_0;
    end
  end

  // Interrupt latency measurement, one event per excursion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_active_reg <= 1'b0;
      lat_flag_reg <= 1'b0;
      lat_count_reg <= 16'h0000;
    end else if (ev.fetch_ext_vector || !ev.ext_int_request) begin
      lat_active_reg <= 1'b0;
      lat_flag_reg <= 1'b0;
      lat_count_reg <= 16'h0000;
    end else begin
      lat_active_reg <= 1'b1;
      if (lat_count_reg != 16'hFFFF) begin
        lat_count_reg <= lat_count_reg + 16'h0001;
      end
      if (lat_event) begin
        lat_flag_reg <= 1'b1;
      end
    end
  end

  assign lat_event = lat_active_reg && !lat_flag_reg &&
                     (lat_count_reg > lat_thresh_reg);

  always_comb begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      inc[i] = event_inc(sel_reg[i], ev,
                         ev.watchpoint_indication_0 && !wp_prev_reg,
                         lat_event);
      sum[i] = {1'b0, count_reg[i]} + {30'h0, inc[i]};
      wr_count[i] = req.wr && slot_hit(req.addr, OFS_COUNTER_0, i);
      wr_ctrl[i] = req.wr && slot_hit(req.addr, OFS_CONTROL_0, i);
    end
  end

  // Counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        count_reg[i] <= COUNTER_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (wr_count[i]) begin
          count_reg[i] <= req.wdata;
        end else if (enable_reg[i] && !freeze_reg) begin
          count_reg[i] <= sum[i][COUNT_W-1:0];
        end
      end
    end
  end

  // Overflow pulses and sticky status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_event <= 4'h0;
      ovf_status_reg <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        overflow_event[i] <= !wr_count[i] && enable_reg[i] && !freeze_reg &&
                             sum[i][COUNT_W];
        if (!wr_count[i] && enable_reg[i] && !freeze_reg &&
            sum[i][COUNT_W]) begin
          ovf_status_reg[i] <= 1'b1;
        end else if (req.wr && req.addr == OFS_OVF_STATUS &&
                     req.wdata[i]) begin
          ovf_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perf_irq <= 1'b0;
    end else begin
      perf_irq <= |(ovf_status_reg & ovf_ie_reg);
    end
  end

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= 4'h0;
      ovf_ie_reg <= 4'h0;
      freeze_reg <= 1'b0;
      lat_thresh_reg <= LAT_THRESH_RESET;
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        sel_reg[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (wr_ctrl[i]) begin
          enable_reg[i] <= req.wdata[CTRL_EN_BIT];
          ovf_ie_reg[i] <= req.wdata[CTRL_OVF_IE_BIT];
          sel_reg[i] <= req.wdata[CTRL_SEL_LSB +: EVENT_SEL_W];
        end
      end
      if (req.wr && req.addr == OFS_GLOBAL_CTRL) begin
        freeze_reg <= req.wdata[0];
      end
      if (req.wr && req.addr == OFS_LAT_THRESH) begin
        lat_thresh_reg <= req.wdata[15:0];
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (req.rd) begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
          if (slot_hit(req.addr, OFS_COUNTER_0, i)) begin
            rdata <= count_reg[i];
          end
          if (slot_hit(req.addr, OFS_CONTROL_0, i)) begin
            rdata <= {17'h0, sel_reg[i], 6'h0, ovf_ie_reg[i], enable_reg[i]};
          end
        end
        if (req.addr == OFS_GLOBAL_CTRL) begin
          rdata <= {31'h0, freeze_reg};
        end
        if (req.addr == OFS_OVF_STATUS) begin
          rdata <= {28'h0, ovf_status_reg};
        end
        if (req.addr == OFS_LAT_THRESH) begin
          rdata <= {16'h0, lat_thresh_reg};
        end
      end
    end
  end

  // Checks
  property p_cycle_count;
    @(posedge clk) disable iff (rst)
    (enable_reg[1] && !freeze_reg && sel_reg[1] == EV_CYCLES && !wr_count[1]
     && ev.halted) |=> $stable(count_reg[1]);
  endproperty
  a_cycle_count: assert property (p_cycle_count)
    else $error("cycle counter advanced while halted");

  property p_disabled_holds;
    @(posedge clk) disable iff (rst)
    (!enable_reg[1] && !wr_count[1]) |=> $stable(count_reg[1]);
  endproperty
  a_disabled_holds: assert property (p_disabled_holds)
    else $error("disabled counter changed");

  property p_wrap;
    @(posedge clk) disable iff (rst)
    (enable_reg[0] && !freeze_reg && !wr_count[0] && sum[0][COUNT_W])
      |=> overflow_event[0] && count_reg[0] < 32'h0000_0004;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow did not wrap with pulse");

  property p_ovf_only_on_wrap;
    @(posedge clk) disable iff (rst)
    overflow_event[2] |-> $past(count_reg[2]) > count_reg[2];
  endproperty
  a_ovf_only_on_wrap: assert property (p_ovf_only_on_wrap)
    else $error("overflow pulse without wrap");

  property p_irq;
    @(posedge clk) disable iff (rst)
    (ovf_status_reg[0] && ovf_ie_reg[0]) |=> perf_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled overflow did not raise interrupt");

  property p_irq_cause;
    @(posedge clk) disable iff (rst)
    perf_irq |-> $past(|(ovf_status_reg & ovf_ie_reg));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without enabled overflow");

  property p_instr_step;
    @(posedge clk) disable iff (rst)
    (enable_reg[2] && !freeze_reg && !wr_count[2] &&
     sel_reg[2] == EV_INSTR_DONE && count_reg[2] < 32'hFFFF_FFF0)
      |=> count_reg[2] - $past(count_reg[2]) == 32'($past(ev.instr_done));
  endproperty
  a_instr_step: assert property (p_instr_step)
    else $error("instruction count step wrong");

  property p_fetch_max;
    @(posedge clk) disable iff (rst)
    inc[3] <= 3'h4;
  endproperty
  a_fetch_max: assert property (p_fetch_max)
    else $error("increment above four");

  property p_watchpoint_once;
    @(posedge clk) disable iff (rst)
    (sel_reg[2] == EV_WATCHPOINT && inc[2] != 3'h0) |=>
      (inc[2] == 3'h0 || sel_reg[2] != EV_WATCHPOINT);
  endproperty
  a_watchpoint_once: assert property (p_watchpoint_once)
    else $error("watchpoint counted twice per assertion");

  property p_lat_once;
    @(posedge clk) disable iff (rst)
    lat_event |=> !lat_event;
  endproperty
  a_lat_once: assert property (p_lat_once)
    else $error("latency excursion counted twice");

  c_overflow: cover property (@(posedge clk) disable iff (rst)
    overflow_event[0]);
  c_irq: cover property (@(posedge clk) disable iff (rst) perf_irq);
  c_latency: cover property (@(posedge clk) disable iff (rst) lat_event);
  c_watchpoint: cover property (@(posedge clk) disable iff (rst)
    sel_reg[2] == EV_WATCHPOINT && inc[2] != 3'h0);
  c_masked_ovf: cover property (@(posedge clk) disable iff (rst)
    ovf_status_reg[1] && !ovf_ie_reg[1]);

  property p_status_follows_ovf;
    @(posedge clk) disable iff (rst)
    overflow_event[1] |-> ovf_status_reg[1];
  endproperty
  a_status_follows_ovf: assert property (p_status_follows_ovf)
    else $error("overflow did not set status");

  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
    !$past(req.rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");

  property p_freeze_holds;
    @(posedge clk) disable iff (rst)
    (freeze_reg && !wr_count[2]) |=> $stable(count_reg[2]);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds)
    else $error("frozen counter changed");
endmodule

// file: perf_counter_pkg.sv
package perf_counter_pkg;

  localparam int NUM_COUNTERS = 4;
  localparam int COUNT_W = 32;
  localparam int EVENT_SEL_W = 7;
  localparam int ADDR_W = 8;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_COUNTER_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_0 = 8'h10;
  localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h20;
  localparam logic [7:0] OFS_OVF_STATUS = 8'h24;
  localparam logic [7:0] OFS_LAT_THRESH = 8'h28;

  // Control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OVF_IE_BIT = 1;
  localparam int CTRL_SEL_LSB = 8;

  // Reset values
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  localparam logic [15:0] LAT_THRESH_RESET = 16'h0010;

  // Event codes
  localparam logic [6:0] EV_CYCLES = 7'h01;
  localparam logic [6:0] EV_INSTR_DONE = 7'h02;
  localparam logic [6:0] EV_WORDS_FETCHED = 7'h03;
  localparam logic [6:0] EV_BRANCH = 7'h04;
  localparam logic [6:0] EV_BRANCH_LINK = 7'h05;
  localparam logic [6:0] EV_COND_BRANCH = 7'h06;
  localparam logic [6:0] EV_TAKEN_BRANCH = 7'h07;
  localparam logic [6:0] EV_TAKEN_COND = 7'h08;
  localparam logic [6:0] EV_LOAD = 7'h09;
  localparam logic [6:0] EV_STORE = 7'h0A;
  localparam logic [6:0] EV_INTEGER = 7'h0B;
  localparam logic [6:0] EV_MULTIPLY = 7'h0C;
  localparam logic [6:0] EV_DIVIDE = 7'h0D;
  localparam logic [6:0] EV_RFI = 7'h0E;
  localparam logic [6:0] EV_DECODE_STALL = 7'h0F;
  localparam logic [6:0] EV_ISSUE_STALL = 7'h10;
  localparam logic [6:0] EV_BRANCH_STALL = 7'h11;
  localparam logic [6:0] EV_LOAD_STALL = 7'h12;
  localparam logic [6:0] EV_INT_TAKEN = 7'h13;
  localparam logic [6:0] EV_EXT_INT_TAKEN = 7'h14;
  localparam logic [6:0] EV_WDOG_INT_TAKEN = 7'h15;
  localparam logic [6:0] EV_WATCHPOINT = 7'h16;
  localparam logic [6:0] EV_INT_LATENCY = 7'h17;

  // Per-cycle indications from the core pipeline
  typedef struct packed {
    logic waiting;
    logic halted;
    logic stopped;
    logic debug_active;
    logic [1:0] instr_done;
    logic [2:0] words_fetched;
    logic branch;
    logic branch_link;
    logic cond_branch;
    logic taken_branch;
    logic taken_cond;
    logic load;
    logic store;
    logic integer_op;
    logic multiply;
    logic divide;
    logic rfi;
    logic decode_empty;
    logic issue_stall;
    logic branch_stall;
    logic load_stall;
    logic int_taken;
    logic ext_int_taken;
    logic wdog_int_taken;
    logic watchpoint_indication_0;
    logic ext_int_request;
    logic fetch_ext_vector;
  } core_events_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// file: core_event_source.sv
`timescale 1ns/1ps
module core_event_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control: 0 quiet, 1 random, 2 held interrupt request
  input wire logic [1:0] mode,
  input wire logic [31:0] rnd,
  // Pipeline indications
  output perf_counter_pkg::core_events_t ev
);
  import perf_counter_pkg::*;

  core_events_t nxt;

  always_comb begin
    nxt = core_events_t'(rnd[29:0]);
    if (nxt.words_fetched > 3'h4) begin
      nxt.words_fetched = {1'b0, rnd[1:0]};
    end
    if (mode != 2'h1) begin
      nxt = '0;
      nxt.ext_int_request = (mode == 2'h2);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev <= '0;
    end else begin
      ev <= nxt;
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import perf_counter_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [1:0] mode = 2'h0;
  logic [31:0] rnd = 32'hFA2DE98D;
  core_events_t ev;
  logic [31:0] rdata;
  logic [3:0] overflow_event;
  logic perf_irq;
  int n_fail = 0;
  int check_count = 0;
  // Reference state
  logic [31:0] cnt[4];
  logic [31:0] ctl[4];
  logic frz;
  logic [3:0] sts;
  logic [15:0] thr;
  logic wp_q;
  logic [15:0] lat;
  logic lat_done;
  logic [31:0] rd_exp;
  logic rd_pend = 1'b0;
  logic [3:0] ovf_exp = 4'h0;

  always #12.5 clk = ~clk;

  always @(posedge clk) rnd <= xs(rnd);

  core_event_source src (.clk(clk), .rst(rst), .mode(mode), .rnd(rnd),
    .ev(ev));

  core_performance_event_counters dut (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .ev(ev), .overflow_event(overflow_event),
    .perf_irq(perf_irq));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [2:0] inc(input logic [6:0] s,
      input core_events_t e, input logic wp, input logic lh);
    logic [23:0] one;
    one = {lh, wp,
      e.wdog_int_taken, e.ext_int_taken, e.int_taken,
      e.load_stall, e.branch_stall,
      e.issue_stall, e.decode_empty,
      e.rfi, e.divide,
      e.multiply, e.integer_op, e.store, e.load,
      e.taken_cond, e.taken_branch, e.cond_branch,
      e.branch_link, e.branch, 4'h0};
    if (s == EV_CYCLES) begin
      return {2'h0, !(e.waiting || e.halted || e.stopped ||
        e.debug_active)};
    end
    if (s == EV_INSTR_DONE) return {1'b0, e.instr_done};
    if (s == EV_WORDS_FETCHED) begin
      return (e.words_fetched > 3'h4) ? 3'h4 : e.words_fetched;
    end
    return (s < 7'h18) ? {2'h0, one[s[4:0]]} : 3'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic wait_irq(input logic lv);
    for (int k = 0; k < 40 && perf_irq !== lv; k++) @(posedge clk);
    chk("perf_irq", {31'h0, lv}, {31'h0, perf_irq});
    if (perf_irq !== lv) results();
  endtask

  // Cycle-accurate reference, compared on every edge
  always @(posedge clk) begin : model
    logic [32:0] sum;
    logic [3:0] wrap;
    logic [7:0] a;
    logic hit;
    if (rd_pend) chk("rdata", rd_exp, rdata);
    else chk("rdata idle", 32'h0, rdata);
    chk("overflow_event", 32'(ovf_exp), 32'(overflow_event));
    a = req.addr;
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] = 32'h0;
        ctl[i] = 32'h0;
      end
      frz = 1'b0;
      sts = 4'h0;
      thr = LAT_THRESH_RESET;
      wp_q = 1'b0;
      lat = 16'h0;
      lat_done = 1'b0;
      rd_pend = 1'b0;
      ovf_exp = 4'h0;
    end else begin
      rd_pend = req.rd;
      rd_exp = 32'h0;
      if (a < 8'h10) rd_exp = cnt[a[3:2]];
      else if (a < 8'h20) rd_exp = ctl[a[3:2]];
      else if (a == 8'h20) rd_exp = {31'h0, frz};
      else if (a == 8'h24) rd_exp = {28'h0, sts};
      else if (a == 8'h28) rd_exp = {16'h0, thr};
      // Cycles already waited must exceed the threshold, once per request
      hit = lat > thr && !lat_done;
      if (!ev.ext_int_request || ev.fetch_ext_vector) begin
        lat = 16'h0;
        lat_done = 1'b0;
      end else begin
        if (lat != 16'hFFFF) lat = lat + 16'h1;
        if (hit) lat_done = 1'b1;
      end
      wrap = 4'h0;
      for (int i = 0; i < 4; i++) begin
        sum = {1'b0, cnt[i]} + inc(ctl[i][14:8], ev,
          ev.watchpoint_indication_0 && !wp_q, hit);
        if (req.wr && a == 8'(4 * i)) begin
          cnt[i] = req.wdata;
        end else if (ctl[i][0] && !frz) begin
          cnt[i] = sum[31:0];
          wrap[i] = sum[32];
        end
        if (req.wr && a == 8'h10 + 8'(4 * i)) ctl[i] = req.wdata & 32'h7F03;
      end
      wp_q = ev.watchpoint_indication_0;
      if (req.wr && a == 8'h20) frz = req.wdata[0];
      if (req.wr && a == 8'h24) sts = sts & ~req.wdata[3:0];
      if (req.wr && a == 8'h28) thr = req.wdata[15:0];
      sts = sts | wrap;
      ovf_exp = wrap;
    end
  end

  initial begin
    #2500000;
    n_fail++;
    results();
  end

  initial begin
    logic [31:0] st;
    logic [7:0] a;
    logic [31:0] d;
    st = 32'hFA2DE98D;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 64; k += 4) bus(1'b0, 8'(k), 32'h0);
    mode <= 2'h1;
    // Every event code spread over the four counters
    for (int c = 0; c < 24; c += 4) begin
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, 8'h10 + 8'(4 * i), {17'h0, 7'(c + i), 8'h01});
      end
      repeat (40) @(posedge clk);
      for (int i = 0; i < 4; i++) bus(1'b0, 8'(4 * i), 32'h0);
    end
    // Wrap with and without the interrupt enable
    mode <= 2'h0;
    bus(1'b1, 8'h10, 32'h0000_0103);
    bus(1'b1, 8'h00, 32'hFFFF_FFF0);
    wait_irq(1'b1);
    bus(1'b1, 8'h24, 32'h0000_000F);
    wait_irq(1'b0);
    bus(1'b1, 8'h14, 32'h0000_0101);
    bus(1'b1, 8'h04, 32'hFFFF_FFFE);
    repeat (8) @(posedge clk);
    chk("perf_irq masked", 32'h0, {31'h0, perf_irq});
    bus(1'b1, 8'h24, 32'h0000_000F);
    // Interrupt latency below and above the threshold
    bus(1'b1, 8'h28, 32'h0000_0004);
    bus(1'b1, 8'h10, {17'h0, EV_INT_LATENCY, 8'h01});
    bus(1'b1, 8'h00, 32'h0);
    mode <= 2'h2;
    repeat (2) @(posedge clk);
    mode <= 2'h0;
    repeat (4) @(posedge clk);
    mode <= 2'h2;
    repeat (30) @(posedge clk);
    mode <= 2'h0;
    bus(1'b0, 8'h00, 32'h0);
    // Random register traffic over live events
    mode <= 2'h1;
    repeat (500) begin
      st = xs(st);
      a = {2'b0, st[5:2], 2'b0};
      d = st[9] ? {28'hFFFFFFF, st[13:10]} : xs(st) | 32'h0000_0100;
      if (st[8]) bus(1'b0, a, 32'h0);
      else bus(1'b1, a, d);
      repeat (st[15:14]) @(posedge clk);
    end
    results();
  end
endmodule
